// [common/opv_pkg.sv]
// shared constants and types for the one-pin voltage interface
`default_nettype none
package opv_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    // startup time before the interface accepts data, in microseconds
    localparam int unsigned STARTUP_US       = 170;
    localparam int unsigned STARTUP_CYC      = STARTUP_US * CLK_MHZ;
    // mode-change timeout, longest time, microseconds
    localparam int unsigned TIMEOUT_US       = 520;
    localparam int unsigned TIMEOUT_CYC      = TIMEOUT_US * CLK_MHZ;
    // acknowledge low time, longest, microseconds
    localparam int unsigned ACK_LOW_US       = 520;
    localparam int unsigned ACK_LOW_CYC      = ACK_LOW_US * CLK_MHZ;
    // delay from last falling edge to pull-down, microseconds
    localparam int unsigned ACK_VALID_US     = 2;
    localparam int unsigned ACK_VALID_CYC    = ACK_VALID_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 18;
    localparam int unsigned BYTE_BITS        = 8;
    localparam int unsigned CODE_W           = 5;
    localparam logic [1:0]  SEL_CONV1        = 2'h0;
    localparam logic [1:0]  SEL_CONV1_UPPER  = 2'h1;
    localparam logic [1:0]  SEL_CONV2        = 2'h2;
    localparam logic [1:0]  SEL_FORBIDDEN    = 2'h3;
    localparam logic [4:0]  CONV1_RESET      = 5'h00;
    localparam logic [4:0]  CONV2_RESET      = 5'h00;
    localparam int unsigned ACK_FLAG_POS     = 7;
    localparam int unsigned SEL_HI_POS       = 6;
    localparam int unsigned SEL_LO_POS       = 5;

    typedef struct packed {
        logic       valid;
        logic       bit_val;
        logic       error;
    } opv_bit_s;
endpackage : opv_pkg
`default_nettype wire

// [rtl/opv_bit_decoder.sv]
// classifies one bit from measured high and low times
`timescale 1ns/10ps
`default_nettype none
module opv_bit_decoder #(
    parameter int unsigned CNT_W = 18
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_fall,
    input  wire logic [CNT_W-1:0] i_low_cnt,
    input  wire logic [CNT_W-1:0] i_high_cnt,
    output opv_pkg::opv_bit_s     o_bit
);
    opv_pkg::opv_bit_s bit_reg;
    opv_pkg::opv_bit_s bit_next;

    always_comb begin
        bit_next = '0;
        if (i_fall) begin
            bit_next.valid = 1'b1;
            // one counts only when high is at least twice low, and the mirror for zero
            if ({1'b0, i_high_cnt} >= {i_low_cnt, 1'b0}) begin
                bit_next.bit_val = 1'b1;
            end else if ({1'b0, i_low_cnt} >= {i_high_cnt, 1'b0}) begin
                bit_next.bit_val = 1'b0;
            end else begin
                bit_next.error = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_reg <= '0;
        end else begin
            bit_reg <= bit_next;
        end
    end

    assign o_bit = bit_reg;
endmodule : opv_bit_decoder
`default_nettype wire

// [rtl/opv_top.sv]
// one-pin voltage interface receiver with acknowledge and mode control
`timescale 1ns/10ps
`default_nettype none
module opv_top #(
    parameter logic [7:0]  DEV_ADDR    = 8'h5A,  // arbitrary value
    parameter int unsigned STARTUP_CYC = opv_pkg::STARTUP_CYC,
    parameter int unsigned TIMEOUT_CYC = opv_pkg::TIMEOUT_CYC,
    parameter int unsigned ACK_LOW_CYC = opv_pkg::ACK_LOW_CYC,
    parameter int unsigned ACK_VAL_CYC = opv_pkg::ACK_VALID_CYC
) (
    input  wire logic       I_MCLK,
    input  wire logic       I_NRST,
    input  wire logic       I_MODE_DATA,
    input  wire logic       I_CONVERTER1_ENABLE,
    input  wire logic       I_CONVERTER2_ENABLE,
    output logic            O_MODE_DATA,
    output logic            O_MODE_DATA_OE,
    output logic [4:0]      O_CONVERTER1_VOLTAGE_SELECT,
    output logic [4:0]      O_CONVERTER2_VOLTAGE_SELECT,
    output logic            O_CONVERTER1_USE_DEFAULT_SET_PIN,
    output logic            O_CONVERTER1_SOFT_START,
    output logic            O_CONVERTER2_SOFT_START,
    output logic            O_FORCED_PWM,
    output logic            O_SHUTDOWN,
    output logic            O_READY
);
    localparam int unsigned W = opv_pkg::CNT_W;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_STARTUP,
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_ACK_WAIT,
        ST_ACK
    } opv_state_e;

    opv_state_e        state_reg, state_next;
    logic [W-1:0]      low_cnt_reg, low_cnt_next;
    logic [W-1:0]      high_cnt_reg, high_cnt_next;
    logic [W-1:0]      tmr_reg, tmr_next;
    logic [15:0]       shift_reg, shift_next;
    logic [4:0]        nbits_reg, nbits_next;
    logic              err_reg, err_next;
    logic              line_reg;
    logic [4:0]        conv1_reg, conv1_next;
    logic [4:0]        conv2_reg, conv2_next;
    logic              pwm_reg, pwm_next;
    logic              oe_reg, oe_next;
    logic [1:0]        en_reg;
    logic              fall;
    logic              any_en;
    opv_pkg::opv_bit_s dec;

    assign any_en = I_CONVERTER1_ENABLE | I_CONVERTER2_ENABLE;
    assign fall   = line_reg & ~I_MODE_DATA;

    // high time is measured up to the fall that closes the bit
    opv_bit_decoder #(
        .CNT_W (W)
    ) u_dec (
        .i_clk      (I_MCLK),
        .i_nrst     (I_NRST),
        .i_fall     (fall && state_reg == ST_HIGH),
        .i_low_cnt  (low_cnt_reg),
        .i_high_cnt (high_cnt_reg),
        .o_bit      (dec)
    );

    always_comb begin
        state_next     = state_reg;
        low_cnt_next   = low_cnt_reg;
        high_cnt_next  = high_cnt_reg;
        tmr_next       = tmr_reg;
        shift_next     = shift_reg;
        nbits_next     = nbits_reg;
        err_next       = err_reg;
        conv1_next     = conv1_reg;
        conv2_next     = conv2_reg;
        pwm_next       = pwm_reg;
        oe_next        = 1'b0;

        // the decoder answers one cycle after the fall; fold the bit in here
        if (dec.valid) begin
            nbits_next = nbits_reg + 5'h01;
            // the ninth period is the end-of-stream low plus start high between the bytes, not data
            if (nbits_reg != 5'h08) begin
                shift_next = {shift_reg[14:0], dec.bit_val};
                if (dec.error) begin
                    err_next = 1'b1;
                end
            end
        end

        if (I_MODE_DATA) begin
            pwm_next = 1'b1;
        end

        unique case (state_reg)
            ST_OFF: begin
                tmr_next = '0;
                if (any_en) begin
                    state_next = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                tmr_next = tmr_reg + 1'b1;
                if (tmr_reg >= W'(STARTUP_CYC - 1)) begin
                    state_next = ST_IDLE;
                    tmr_next   = '0;
                end
            end
            ST_IDLE: begin
                if (fall) begin
                    state_next   = ST_LOW;
                    low_cnt_next = W'(1);
                    nbits_next   = '0;
                    err_next     = 1'b0;
                end else if (I_MODE_DATA) begin
                    low_cnt_next = '0;
                end else if (pwm_reg) begin
                    // the low after a finished frame still runs toward power save
                    low_cnt_next = low_cnt_reg + 1'b1;
                    if (low_cnt_reg >= W'(TIMEOUT_CYC - 1)) begin
                        pwm_next = 1'b0;
                    end
                end
            end
            ST_LOW: begin
                if (I_MODE_DATA) begin
                    state_next    = ST_HIGH;
                    high_cnt_next = W'(1);
                end else if (low_cnt_reg >= W'(TIMEOUT_CYC - 1)) begin
                    // long low: abandon decoding, drop to power save
                    pwm_next   = 1'b0;
                    state_next = ST_IDLE;
                end else begin
                    // count only samples still low, else the low time reads one too long
                    low_cnt_next = low_cnt_reg + 1'b1;
                end
            end
            ST_HIGH: begin
                high_cnt_next = high_cnt_reg + 1'b1;
                if (fall) begin
                    state_next   = ST_LOW;
                    low_cnt_next = W'(1);
                end else if (high_cnt_reg >= W'(TIMEOUT_CYC - 1)) begin
                    // long high: abandon the unfinished frame, its open bit is never decoded
                    state_next = ST_IDLE;
                end
            end
            ST_ACK_WAIT: begin
                tmr_next = tmr_reg + 1'b1;
                if (tmr_reg >= W'(ACK_VAL_CYC - 1)) begin
                    state_next = ST_ACK;
                    tmr_next   = '0;
                    oe_next    = 1'b1;
                end
            end
            ST_ACK: begin
                tmr_next = tmr_reg + 1'b1;
                oe_next  = 1'b1;
                if (tmr_reg >= W'(ACK_LOW_CYC - 1)) begin
                    state_next = ST_IDLE;
                    tmr_next   = '0;
                    oe_next    = 1'b0;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase

        // last data bit: fifteen bits are already in, the gap period was skipped
        if (dec.valid && nbits_reg == 5'h10) begin
            // the closing end-of-stream low must not become the next frame's first bit
            state_next = ST_IDLE;
            if (!err_reg && !dec.error && shift_reg[14:7] == DEV_ADDR) begin
                unique case (shift_reg[5:4])
                    opv_pkg::SEL_CONV1:       conv1_next = {shift_reg[3:0], dec.bit_val};
                    opv_pkg::SEL_CONV2:       conv2_next = {shift_reg[3:0], dec.bit_val};
                    opv_pkg::SEL_CONV1_UPPER: conv1_next = conv1_reg;
                    opv_pkg::SEL_FORBIDDEN:   conv1_next = conv1_reg;
                endcase
                if (shift_reg[6]) begin
                    state_next = ST_ACK_WAIT;
                    tmr_next   = '0;
                end
            end
            // bad transfer: line left to the pull-up
            nbits_next = '0;
        end

        if (!any_en) begin
            state_next = ST_OFF;
            oe_next    = 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_reg     <= ST_OFF;
            low_cnt_reg   <= '0;
            high_cnt_reg  <= '0;
            tmr_reg       <= '0;
            shift_reg     <= '0;
            nbits_reg     <= '0;
            err_reg       <= 1'b0;
            line_reg      <= 1'b0;
            conv1_reg     <= opv_pkg::CONV1_RESET;
            conv2_reg     <= opv_pkg::CONV2_RESET;
            pwm_reg       <= 1'b0;
            oe_reg        <= 1'b0;
            en_reg        <= 2'h0;
        end else begin
            state_reg     <= state_next;
            low_cnt_reg   <= low_cnt_next;
            high_cnt_reg  <= high_cnt_next;
            tmr_reg       <= tmr_next;
            shift_reg     <= shift_next;
            nbits_reg     <= nbits_next;
            err_reg       <= err_next;
            line_reg      <= I_MODE_DATA;
            conv1_reg     <= conv1_next;
            conv2_reg     <= conv2_next;
            pwm_reg       <= pwm_next;
            oe_reg        <= oe_next;
            en_reg        <= {I_CONVERTER2_ENABLE, I_CONVERTER1_ENABLE};
        end
    end

    // outputs straight from flops, except O_MODE_DATA tied to 0
    logic       ss1_reg, ss2_reg, shdn_reg, rdy_reg, dflt_reg;
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ss1_reg  <= 1'b0;
            ss2_reg  <= 1'b0;
            shdn_reg <= 1'b1;
            rdy_reg  <= 1'b0;
            dflt_reg <= 1'b1;
        end else begin
            ss1_reg  <= I_CONVERTER1_ENABLE & ~en_reg[0];
            ss2_reg  <= I_CONVERTER2_ENABLE & ~en_reg[1];
            shdn_reg <= ~any_en;
            rdy_reg  <= (state_next != ST_OFF) && (state_next != ST_STARTUP);
            dflt_reg <= (conv1_next == 5'h00);
        end
    end

    assign O_MODE_DATA                      = 1'b0;
    assign O_MODE_DATA_OE                   = oe_reg;
    assign O_CONVERTER1_VOLTAGE_SELECT      = conv1_reg;
    assign O_CONVERTER2_VOLTAGE_SELECT      = conv2_reg;
    assign O_CONVERTER1_USE_DEFAULT_SET_PIN = dflt_reg;
    assign O_CONVERTER1_SOFT_START          = ss1_reg;
    assign O_CONVERTER2_SOFT_START          = ss2_reg;
    assign O_FORCED_PWM                     = pwm_reg;
    assign O_SHUTDOWN                       = shdn_reg;
    assign O_READY                          = rdy_reg;
endmodule : opv_top
`default_nettype wire

// [sim/opv_top_props.sv]
// assertion checker for the one-pin voltage interface top
`timescale 1ns/10ps
`default_nettype none
module opv_top_props #(
    parameter int unsigned STARTUP_CYC = 200,
    parameter int unsigned TIMEOUT_CYC = 400,
    parameter int unsigned ACK_LOW_CYC = 100,
    parameter int unsigned ACK_VAL_CYC = 20
) (
    input wire logic       I_MCLK,
    input wire logic       I_NRST,
    input wire logic       I_MODE_DATA,
    input wire logic       I_CONVERTER1_ENABLE,
    input wire logic       I_CONVERTER2_ENABLE,
    input wire logic       O_MODE_DATA_OE,
    input wire logic [4:0] O_CONVERTER1_VOLTAGE_SELECT,
    input wire logic [4:0] O_CONVERTER2_VOLTAGE_SELECT,
    input wire logic       O_CONVERTER1_USE_DEFAULT_SET_PIN,
    input wire logic       O_CONVERTER1_SOFT_START,
    input wire logic       O_CONVERTER2_SOFT_START,
    input wire logic       O_FORCED_PWM,
    input wire logic       O_SHUTDOWN,
    input wire logic       O_READY
);
    logic [19:0] oe_cnt_reg, low_cnt_reg, en_cnt_reg, fall_age_reg;
    logic        line_prev_reg;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    // 20-bit counters outlast any run of this bench, so no saturation
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            oe_cnt_reg    <= '0;
            low_cnt_reg   <= '0;
            en_cnt_reg    <= '0;
            fall_age_reg  <= '0;
            line_prev_reg <= 1'h1;
        end else begin
            oe_cnt_reg    <= O_MODE_DATA_OE ? oe_cnt_reg + 20'h1 : 20'h0;
            low_cnt_reg   <= I_MODE_DATA ? 20'h0 : low_cnt_reg + 20'h1;
            en_cnt_reg    <= (I_CONVERTER1_ENABLE || I_CONVERTER2_ENABLE) ? en_cnt_reg + 20'h1 : 20'h0;
            fall_age_reg  <= (line_prev_reg && !I_MODE_DATA) ? 20'h0 : fall_age_reg + 20'h1;
            line_prev_reg <= I_MODE_DATA;
        end
    end
    property p_oe_len;
        !O_MODE_DATA_OE && oe_cnt_reg != 0 |-> oe_cnt_reg == ACK_LOW_CYC;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("pull-down length wrong");
    property p_oe_delay;
        $rose(O_MODE_DATA_OE) |-> fall_age_reg inside {[ACK_VAL_CYC - 1 : ACK_VAL_CYC + 4]};
    endproperty
    a_oe_delay: assert property (p_oe_delay) else $error("pull-down delay wrong");
    property p_pwm_rise;
        $rose(I_MODE_DATA) && O_READY |-> ##[1:3] O_FORCED_PWM;
    endproperty
    a_pwm_rise: assert property (p_pwm_rise) else $error("no forced pwm on high line");
    property p_pwm_hold;
        O_FORCED_PWM && !I_MODE_DATA && O_READY && low_cnt_reg < TIMEOUT_CYC - 3 |=> O_FORCED_PWM;
    endproperty
    a_pwm_hold: assert property (p_pwm_hold) else $error("pwm dropped early");
    property p_pwm_timeout;
        low_cnt_reg == TIMEOUT_CYC + 3 && O_READY |-> !O_FORCED_PWM;
    endproperty
    a_pwm_timeout: assert property (p_pwm_timeout) else $error("no power save after timeout");
    property p_ready;
        $rose(O_READY) |-> en_cnt_reg inside {[STARTUP_CYC - 2 : STARTUP_CYC + 3]};
    endproperty
    a_ready: assert property (p_ready) else $error("startup time wrong");
    property p_off;
        (!I_CONVERTER1_ENABLE && !I_CONVERTER2_ENABLE) [*2] |-> O_SHUTDOWN && !O_READY;
    endproperty
    a_off: assert property (p_off) else $error("not shut down");
    property p_on;
        (I_CONVERTER1_ENABLE || I_CONVERTER2_ENABLE) [*2] |-> !O_SHUTDOWN;
    endproperty
    a_on: assert property (p_on) else $error("shutdown while enabled");
    property p_soft1;
        $rose(I_CONVERTER1_ENABLE) |-> ##[1:3] O_CONVERTER1_SOFT_START ##1 !O_CONVERTER1_SOFT_START;
    endproperty
    a_soft1: assert property (p_soft1) else $error("soft start 1 pulse wrong");
    property p_soft2;
        $rose(I_CONVERTER2_ENABLE) |-> ##[1:3] O_CONVERTER2_SOFT_START ##1 !O_CONVERTER2_SOFT_START;
    endproperty
    a_soft2: assert property (p_soft2) else $error("soft start 2 pulse wrong");
    property p_code;
        !$stable(O_CONVERTER1_VOLTAGE_SELECT) || !$stable(O_CONVERTER2_VOLTAGE_SELECT) |-> fall_age_reg <= 4;
    endproperty
    a_code: assert property (p_code) else $error("code changed away from a frame end");
    property p_dflt;
        $stable(O_CONVERTER1_VOLTAGE_SELECT) [*2] |->
            O_CONVERTER1_USE_DEFAULT_SET_PIN == (O_CONVERTER1_VOLTAGE_SELECT == 5'h00);
    endproperty
    a_dflt: assert property (p_dflt) else $error("default pin select wrong");
endmodule : opv_top_props
bind opv_top opv_top_props #(.STARTUP_CYC(STARTUP_CYC), .TIMEOUT_CYC(TIMEOUT_CYC), .ACK_LOW_CYC(ACK_LOW_CYC),
    .ACK_VAL_CYC(ACK_VAL_CYC)) u_props (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_MODE_DATA(I_MODE_DATA),
    .I_CONVERTER1_ENABLE(I_CONVERTER1_ENABLE), .I_CONVERTER2_ENABLE(I_CONVERTER2_ENABLE),
    .O_MODE_DATA_OE(O_MODE_DATA_OE), .O_CONVERTER1_VOLTAGE_SELECT(O_CONVERTER1_VOLTAGE_SELECT),
    .O_CONVERTER2_VOLTAGE_SELECT(O_CONVERTER2_VOLTAGE_SELECT),
    .O_CONVERTER1_USE_DEFAULT_SET_PIN(O_CONVERTER1_USE_DEFAULT_SET_PIN),
    .O_CONVERTER1_SOFT_START(O_CONVERTER1_SOFT_START), .O_CONVERTER2_SOFT_START(O_CONVERTER2_SOFT_START),
    .O_FORCED_PWM(O_FORCED_PWM), .O_SHUTDOWN(O_SHUTDOWN), .O_READY(O_READY));
`default_nettype wire

// [sim/opv_host_model.sv]
// host master model pulling the shared mode/data line low
`timescale 1ns/10ps
`default_nettype none
module opv_host_model (
    input  wire logic i_clk,
    input  wire logic i_line,
    output var logic  o_pull
);
    initial o_pull = 1'h0;
    // open-drain only: the pull-up makes every high level
    task automatic hold(input logic pull, input int unsigned n);
        o_pull = pull;
        repeat (n) @(negedge i_clk);
    endtask : hold
    // outside the bad bit, the longer phase is exactly twice the shorter, the tightest legal ratio
    task automatic send_frame(input logic [15:0] w, input int unsigned u, input logic bad, output logic acked);
        for (int i = 15; i >= 0; i--) begin
            if (i % 8 == 7) hold(1'h0, 10);
            if (bad && i == 3) begin
                hold(1'h1, u);
                hold(1'h0, u);
            end else begin
                hold(1'h1, w[i] ? u : 2 * u);
                hold(1'h0, w[i] ? 2 * u : u);
            end
            if (i % 8 == 0) hold(1'h1, 26);
        end
        hold(1'h0, 3);
        acked = !i_line;
        hold(1'h0, 120);
    endtask : send_frame
endmodule : opv_host_model
`default_nettype wire

// [sim/opv_top_tb.sv]
// self-checking bench for the one-pin voltage interface
`timescale 1ns/10ps
`default_nettype none
module opv_top_tb;
    localparam logic [7:0] ADDR = 8'h3C; // arbitrary device address
    logic       mclk, nrst, en1, en2, pull, line, oe, od, ss1, ss2, pwm, sd, rdy, dflt, live;
    logic [4:0] v1, v2, e1, e2;
    int         fail_count, comparisons, cyc;
    assign line = ~pull & (oe ? od : 1'h1);
    opv_top #(.DEV_ADDR(ADDR), .STARTUP_CYC(200), .TIMEOUT_CYC(400), .ACK_LOW_CYC(100), .ACK_VAL_CYC(20)) u_dut (
        .I_MCLK(mclk), .I_NRST(nrst), .I_MODE_DATA(line), .I_CONVERTER1_ENABLE(en1), .I_CONVERTER2_ENABLE(en2),
        .O_MODE_DATA(od), .O_MODE_DATA_OE(oe), .O_CONVERTER1_VOLTAGE_SELECT(v1), .O_CONVERTER2_VOLTAGE_SELECT(v2),
        .O_CONVERTER1_USE_DEFAULT_SET_PIN(dflt), .O_CONVERTER1_SOFT_START(ss1), .O_CONVERTER2_SOFT_START(ss2),
        .O_FORCED_PWM(pwm), .O_SHUTDOWN(sd), .O_READY(rdy));
    opv_host_model u_host (.i_clk(mclk), .i_line(line), .o_pull(pull));
    always #2.5 mclk = ~mclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic frame(input logic [7:0] a, input logic [7:0] d, input int unsigned u, input logic bad,
                         input logic ack);
        logic got;
        u_host.send_frame({a, d}, u, bad, got);
        if (live && a == ADDR && !bad && d[6:5] == opv_pkg::SEL_CONV1) e1 = d[4:0];
        if (live && a == ADDR && !bad && d[6:5] == opv_pkg::SEL_CONV2) e2 = d[4:0];
        chk(16'({got, dflt, v1, v2}), 16'({ack, e1 == 5'h00, e1, e2}));
    endtask : frame
    initial begin
        mclk = 1'h0;
        nrst = 1'h0;
        en1 = 1'h0;
        en2 = 1'h0;
        live = 1'h0;
        e1 = opv_pkg::CONV1_RESET;
        e2 = opv_pkg::CONV2_RESET;
        fail_count = 0;
        comparisons = 0;
        repeat (12) @(negedge mclk);
        nrst = 1'h1;
        @(negedge mclk);
        chk(16'({sd, rdy, v1, v2}), 16'({2'h2, e1, e2}));
        frame(ADDR, 8'h87, 3, 1'h0, 1'h0);
        en1 = 1'h1;
        repeat (150) @(negedge mclk);
        en2 = 1'h1;
        for (int i = 0; i < 100 && rdy !== 1'h1; i++) @(negedge mclk);
        live = 1'h1;
        chk(16'({sd, rdy, pwm}), 16'h3);
        frame(ADDR, 8'h8F, 3, 1'h0, 1'h1);
        frame(ADDR, 8'hCA, 25, 1'h0, 1'h1);
        frame(ADDR + 8'h01, 8'h9F, 3, 1'h0, 1'h0);
        frame(ADDR, 8'h35, 3, 1'h0, 1'h0);
        frame(ADDR, 8'h75, 3, 1'h0, 1'h0);
        frame(ADDR, 8'hDF, 3, 1'h1, 1'h0);
        frame(ADDR, 8'h00, 9, 1'h0, 1'h0);
        frame(ADDR, 8'h9E, 3, 1'h0, 1'h1);
        // the frame went first and only then the line drops, so nothing is sent inside the timeout
        u_host.hold(1'h1, 450);
        chk(16'(pwm), 16'h0);
        u_host.hold(1'h0, 4);
        chk(16'(pwm), 16'h1);
        en1 = 1'h0;
        en2 = 1'h0;
        repeat (4) @(negedge mclk);
        chk(16'({sd, rdy, v1, v2}), 16'({2'h2, e1, e2}));
        end_of_test();
    end
endmodule : opv_top_tb
`default_nettype wire
